// ---- src/eeprom_pkg.sv ----
// Shared constants of the serial EEPROM command core
package eeprom_pkg;
   // ------------------------------------------------------------
   // Instruction codes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_READ      = 8'h03;
   localparam logic [7:0] OP_WRITE     = 8'h02;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_STRD      = 8'h05;
   localparam logic [7:0] OP_STWR      = 8'h01;
   // ------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------
   localparam int          ADDR_W     = 14;
   localparam int          PAGE_W     = 6;
   localparam logic [13:0] ADDR_TOP   = 14'h3fff;
   localparam logic [13:0] ADDR_ZERO  = 14'h0000;
   localparam logic [13:0] QTR_BASE   = 14'h3000;
   localparam logic [13:0] HALF_BASE  = 14'h2000;
   // ------------------------------------------------------------
   // Status byte fields
   // ------------------------------------------------------------
   localparam int PPE_POS  = 7;
   localparam int BPH_POS  = 3;
   localparam int BPL_POS  = 2;
   localparam int LATCH_POS = 1;
   localparam int BUSY_POS = 0;
   localparam logic [1:0] BP_RESET  = 2'h0;
   localparam logic       PPE_RESET = 1'b0;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ      = 50;
   localparam int WRITE_MS     = 5;
   localparam int WRITE_CYCLES = WRITE_MS * 1000 * CLK_MHZ;
   localparam int BUF_DEPTH    = 2;
endpackage : eeprom_pkg

// ---- src/sync2.sv ----
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   input  wire logic ce_i,
   // Data
   input  wire logic d_i,
   output logic      q_o
);
   logic meta;
   logic next_meta;
   logic next_q;

   always_comb begin
      next_meta = ce_i ? d_i : meta;
      next_q    = ce_i ? meta : q_o;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= RESET_VAL;
         q_o  <= RESET_VAL;
      end else begin
         meta <= next_meta;
         q_o  <= next_q;
      end
   end
endmodule : sync2

// ---- src/byte_buf.sv ----
// Two-entry valid/ready buffer for page write bytes
`timescale 1ns/1ps
module byte_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rstn_i,
   input  wire logic         ce_i,
   input  wire logic         flush_i,
   // Fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wp, rp, next_wp, next_rp;
   logic [PW:0]   cnt, next_cnt;
   logic          push, pop;

   assign in_ready_o  = (cnt != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt != '0);
   assign out_data_o  = mem[rp];
   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;

   always_comb begin
      next_wp  = wp;
      next_rp  = rp;
      next_cnt = cnt;
      if (flush_i) begin
         next_wp  = '0;
         next_rp  = '0;
         next_cnt = '0;
      end else begin
         if (push) next_wp = (wp == PW'(DEPTH-1)) ? '0 : wp + 1'b1;
         if (pop)  next_rp = (rp == PW'(DEPTH-1)) ? '0 : rp + 1'b1;
         next_cnt = cnt + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else if (ce_i) begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
         if (push && !flush_i) mem[wp] <= in_data_i;
      end
   end
endmodule : byte_buf

// ---- src/spi_serial_eeprom_core.sv ----
// Serial EEPROM command core: SPI slave, status, protection, write cycle
//
// Contract
// - Read: opcode 03, 16-bit address, top ignored
// - Read streams bytes, pointer advances each byte
// - Read pointer wraps 3FFFh to 0000h
// - Chip select high ends read
// - Latch set by 06 then deselect
// - Write: opcode 02, address, data bytes
// - Up to 64 bytes within one page
// - Page overflow wraps within same page
// - Commit only on deselect at byte end
// - Array access ignored while busy
// - Opcode 04 clears the latch
// - Latch cleared reset, disable, writes
// - Status read 05 allowed any time
// - Status layout: 7, 3, 2, 1, 0
// - Busy flag one during write cycle
// - Latch bit mirrors latch, ignores protection
// - Opcode 01 writes nonvolatile status bits
// - Block protect codes guard array ranges
// - Pin low plus enable blocks status write
// - Latch clear blocks all writes
// - Standby, latch clear, output off at reset
// - Input sampled on rising clock, MSB first
// - Output changes on falling clock, off deselected
// - Write cycle at most 5 ms
// - Pause input freezes sequence, floats output
`timescale 1ns/1ps
module spi_serial_eeprom_core #(
   parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
   // Clock, reset, enable
   input  wire logic sys_clk_i,
   input  wire logic rstn_i,
   input  wire logic ce_i,
   // SPI pins
   input  wire logic sck_i,
   input  wire logic csn_i,
   input  wire logic si_i,
   input  wire logic holdn_i,
   input  wire logic wpn_i,
   output logic      so_o,
   output logic      so_oen_o,
   // Status view
   output logic      busy_o
);
   localparam int AW = eeprom_pkg::ADDR_W;
   localparam int PW = eeprom_pkg::PAGE_W;
   localparam int CW = $clog2(WRITE_CYCLES + 1);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic sck_s, csn_s, si_s, holdn_s, wpn_s;
   sync2 #(.RESET_VAL(1'b0)) u_sck (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .ce_i(ce_i), .d_i(sck_i), .q_o(sck_s));
   sync2 #(.RESET_VAL(1'b1)) u_csn (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .ce_i(ce_i), .d_i(csn_i), .q_o(csn_s));
   sync2 #(.RESET_VAL(1'b0)) u_si (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .ce_i(ce_i), .d_i(si_i), .q_o(si_s));
   sync2 #(.RESET_VAL(1'b1)) u_hold (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .ce_i(ce_i), .d_i(holdn_i), .q_o(holdn_s));
   sync2 #(.RESET_VAL(1'b1)) u_wp (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .ce_i(ce_i), .d_i(wpn_i), .q_o(wpn_s));

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum {ST_IDLE, ST_OP, ST_ADDR, ST_RDATA, ST_WDATA,
                 ST_SDATA, ST_STAT, ST_DEAD} state_t;
   state_t           state, next_state;
   logic [7:0]       mem [1 << AW];
   logic             sck_d, next_sck_d, csn_d, next_csn_d;
   logic             paused, next_paused;
   logic [2:0]       bitc, next_bitc;
   logic [7:0]       shin, next_shin;
   logic [7:0]       shout, next_shout;
   logic [15:0]      addr_sh, next_addr_sh;
   logic             is_write, next_is_write;
   logic [AW-1:0]    ptr, next_ptr;
   logic             got_byte, next_got_byte;
   logic             wlatch, next_wlatch;
   logic             ppe, next_ppe;
   logic [1:0]       bp, next_bp;
   logic [7:0]       st_new, next_st_new;
   logic             so_q, next_so_q, oen, next_oen;
   logic             pend_arr, next_pend_arr, pend_st, next_pend_st;
   logic [CW-1:0]    wtimer, next_wtimer;
   logic [7:0]       status;
   logic             rise, fall, cs_rise, cs_fall, act;
   logic [7:0]       byte_in;
   logic             buf_in_ready, buf_out_valid, buf_pop, buf_flush;
   logic             buf_push;
   logic [PW+7:0]    buf_out;

   assign status = {ppe, 3'h0, bp, wlatch, busy_o};
   assign rise    = sck_s && !sck_d;
   assign fall    = !sck_s && sck_d;
   assign cs_rise = csn_s && !csn_d;
   assign cs_fall = !csn_s && csn_d;
   assign act     = !csn_s && !paused;
   assign byte_in = {shin[6:0], si_s};
   assign so_o     = so_q;
   assign so_oen_o = oen;
   assign busy_o   = (wtimer != '0);

   // ------------------------------------------------------------
   // Data buffer between serial receive and page shadow
   // ------------------------------------------------------------
   // Each byte travels with its page index; the drain side empties
   // every cycle, far faster than one byte per eight link clocks.
   assign buf_flush = cs_fall;
   assign buf_push  = act && rise && state == ST_WDATA && bitc == 3'h7;
   assign buf_pop   = buf_out_valid;
   byte_buf #(.W(8 + PW), .DEPTH(eeprom_pkg::BUF_DEPTH)) u_buf (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .flush_i(buf_flush),
      .in_valid_i(buf_push), .in_ready_o(buf_in_ready),
      .in_data_i({ptr[PW-1:0], byte_in}),
      .out_valid_o(buf_out_valid), .out_ready_i(buf_pop),
      .out_data_o(buf_out));

   // Array protection by block code
   function automatic logic prot(input logic [1:0] b,
                                 input logic [AW-1:0] a);
      case (b)
         2'h0:    prot = 1'b0;
         2'h1:    prot = (a >= eeprom_pkg::QTR_BASE);
         2'h2:    prot = (a >= eeprom_pkg::HALF_BASE);
         default: prot = 1'b1;
      endcase
   endfunction : prot

   // Page bytes are staged in a shadow so a cancelled write leaves
   // the array untouched; they reach the array only on commit.
   logic [7:0] page_sh [1 << PW];
   logic [(1<<PW)-1:0] page_hit, next_page_hit;

   always_comb begin
      next_state     = state;
      next_sck_d     = sck_s;
      next_csn_d     = csn_s;
      next_paused    = paused;
      next_bitc      = bitc;
      next_shin      = shin;
      next_shout     = shout;
      next_addr_sh   = addr_sh;
      next_is_write  = is_write;
      next_ptr       = ptr;
      next_got_byte  = got_byte;
      next_wlatch    = wlatch;
      next_ppe       = ppe;
      next_bp        = bp;
      next_st_new    = st_new;
      next_so_q      = so_q;
      next_oen       = oen;
      next_pend_arr  = pend_arr;
      next_pend_st   = pend_st;
      next_wtimer    = wtimer;
      next_page_hit  = page_hit;
      if (!csn_s && fall == 1'b0 && !sck_s) next_paused = !holdn_s;
      if (csn_s) next_paused = 1'b0;
      // Output floats while paused and drives the held bit again on resume
      if (paused) next_oen = 1'b1;
      if (paused && !next_paused && !csn_s &&
          (state == ST_RDATA || state == ST_STAT)) next_oen = 1'b0;
      if (busy_o) begin
         next_wtimer = wtimer - 1'b1;
         if (wtimer == CW'(1)) begin
            if (pend_arr) next_wlatch = 1'b0;
            if (pend_st) begin
               next_ppe = st_new[eeprom_pkg::PPE_POS];
               next_bp  = st_new[eeprom_pkg::BPH_POS:eeprom_pkg::BPL_POS];
            end
            next_pend_arr = 1'b0;
            next_pend_st  = 1'b0;
         end
      end
      if (csn_s) begin
         next_state = ST_IDLE;
         next_oen   = 1'b1;
      end
      if (cs_fall) begin
         next_state    = ST_OP;
         next_bitc     = '0;
         next_got_byte = 1'b0;
         next_page_hit = '0;
      end
      if (cs_rise) begin
         if (state == ST_OP && bitc == '0 && got_byte) begin
            if (shin == eeprom_pkg::OP_SET_LATCH && !busy_o)
               next_wlatch = 1'b1;
            if (shin == eeprom_pkg::OP_CLR_LATCH && !busy_o)
               next_wlatch = 1'b0;
         end
         if (state == ST_WDATA && bitc == '0 && got_byte && wlatch
             && !busy_o) begin
            next_pend_arr = 1'b1;
            next_wtimer   = CW'(WRITE_CYCLES);
         end
         if (state == ST_SDATA && bitc == '0 && got_byte && wlatch
             && !busy_o && !(ppe && !wpn_s)) begin
            next_pend_st = 1'b1;
            next_wlatch  = 1'b0;
            next_wtimer  = CW'(WRITE_CYCLES);
         end
      end
      if (act && fall && (state == ST_RDATA || state == ST_STAT)) begin
         next_oen   = 1'b0;
         next_so_q  = shout[7];
         next_shout = {shout[6:0], 1'b0};
      end
      if (act && rise) begin
         next_shin = byte_in;
         next_bitc = bitc + 1'b1;
         if (state == ST_ADDR) next_addr_sh = {addr_sh[14:0], si_s};
         if (bitc == 3'h7) begin
            next_got_byte = 1'b1;
            case (state)
               ST_OP: begin
                  case (byte_in)
                     eeprom_pkg::OP_READ: begin
                        next_state = busy_o ? ST_DEAD : ST_ADDR;
                        next_is_write = 1'b0;
                        next_got_byte = 1'b0;
                     end
                     eeprom_pkg::OP_WRITE: begin
                        next_state = busy_o ? ST_DEAD : ST_ADDR;
                        next_is_write = 1'b1;
                        next_got_byte = 1'b0;
                     end
                     eeprom_pkg::OP_STRD: begin
                        next_state = ST_STAT;
                        next_shout = status;
                     end
                     eeprom_pkg::OP_STWR: begin
                        next_state = ST_SDATA;
                        next_got_byte = 1'b0;
                     end
                     eeprom_pkg::OP_SET_LATCH,
                     eeprom_pkg::OP_CLR_LATCH: next_state = ST_OP;
                     default: next_state = ST_DEAD;
                  endcase
                  // Latch opcodes wait here for the deselect; any further
                  // byte in the same frame kills the frame
                  if (got_byte) next_state = ST_DEAD;
               end
               ST_ADDR: next_got_byte = 1'b0;
               ST_RDATA: begin
                  next_ptr   = ptr + 1'b1;
                  next_shout = mem[ptr + 1'b1];
               end
               ST_WDATA: begin
                  next_ptr = {ptr[AW-1:PW], ptr[PW-1:0] + 1'b1};
                  next_page_hit[ptr[PW-1:0]] = 1'b1;
               end
               ST_SDATA: next_st_new = byte_in;
               ST_STAT:  next_shout = status;
               default:  next_state = state;
            endcase
         end
      end
      // Address phase spans two bytes; got_byte marks the first, the pointer takes the low 14 shifter bits
      if (act && rise && state == ST_ADDR && bitc == 3'h7) begin
         if (got_byte) begin
            next_ptr   = {addr_sh[AW-2:0], si_s};
            next_state = is_write ? ST_WDATA : ST_RDATA;
            next_shout = mem[{addr_sh[AW-2:0], si_s}];
            next_got_byte = 1'b0;
         end else begin
            next_got_byte = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
         sck_d <= 1'b0;  csn_d <= 1'b1;  paused <= 1'b0;
         bitc <= '0;  shin <= '0;  shout <= '0;  addr_sh <= '0;
         is_write <= 1'b0;  ptr <= '0;
         got_byte <= 1'b0;  wlatch <= 1'b0;
         ppe <= eeprom_pkg::PPE_RESET;  bp <= eeprom_pkg::BP_RESET;
         st_new <= '0;  so_q <= 1'b0;  oen <= 1'b1;
         pend_arr <= 1'b0;  pend_st <= 1'b0;  wtimer <= '0;
         page_hit <= '0;
      end else if (ce_i) begin
         state <= next_state;
         sck_d <= next_sck_d;  csn_d <= next_csn_d;  paused <= next_paused;
         bitc <= next_bitc;  shin <= next_shin;  shout <= next_shout;
         addr_sh <= next_addr_sh;  is_write <= next_is_write;
         ptr <= next_ptr;
         got_byte <= next_got_byte;  wlatch <= next_wlatch;
         ppe <= next_ppe;  bp <= next_bp;  st_new <= next_st_new;
         so_q <= next_so_q;  oen <= next_oen;
         pend_arr <= next_pend_arr;  pend_st <= next_pend_st;
         wtimer <= next_wtimer;
         page_hit <= next_page_hit;
      end
   end

   // Array and page shadow storage, no reset by nature of the cells
   always_ff @(posedge sys_clk_i) begin
      if (ce_i) begin
         if (buf_pop)
            page_sh[buf_out[PW+7:8]] <= buf_out[7:0];
         if (cs_rise && state == ST_WDATA && bitc == '0 && got_byte && wlatch
             && !busy_o) begin
            for (int i = 0; i < (1 << PW); i++) begin
               if (page_hit[i] &&
                   !prot(bp, {ptr[AW-1:PW], PW'(i)}))
                  mem[{ptr[AW-1:PW], PW'(i)}] <= page_sh[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_OUT_OFF_DESEL: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) csn_s |=> so_oen_o)
      else $error("output driven while deselected");
   AST_BUSY_LEN: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) $rose(busy_o) |-> busy_o [*8])
      else $error("write cycle ended too soon");
   AST_LATCH_CLEAR_ST: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) $rose(pend_st) |-> !wlatch)
      else $error("latch not cleared on status write");
   AST_NO_WRITE_NO_LATCH: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) (!$past(wlatch) && !$past(busy_o))
      |-> !$rose(busy_o))
      else $error("write started without latch");
   AST_BUSY_FLAG: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) $rose(status[eeprom_pkg::BUSY_POS])
      |-> $past(cs_rise) && (pend_arr || pend_st))
      else $error("busy flag set without a committed write");
   AST_LATCH_BIT: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) (cs_rise && state == ST_OP && bitc == '0
      && got_byte && !busy_o && shin == eeprom_pkg::OP_SET_LATCH)
      |=> status[eeprom_pkg::LATCH_POS])
      else $error("latch bit not set by latch opcode");
   AST_HW_PROT: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) (ppe && !wpn_s && state == ST_SDATA && cs_rise)
      |=> !pend_st)
      else $error("status write accepted under pin protect");
   AST_PAUSE_OFF: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) (paused && state == ST_RDATA) |=>
      $stable(bitc))
      else $error("bits advanced while paused");
   AST_PAUSE_FLOAT: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) (paused && $past(paused)) |-> so_oen_o)
      else $error("output driven while paused");
   AST_BUF_ROOM: assert property (@(posedge sys_clk_i)
      disable iff (!rstn_i) buf_push |-> buf_in_ready)
      else $error("page byte arrived with the buffer full");
   COV_READ: cover property (@(posedge sys_clk_i) state == ST_RDATA);
   COV_WRITE: cover property (@(posedge sys_clk_i) $rose(pend_arr));
   COV_STAT: cover property (@(posedge sys_clk_i) $rose(pend_st));
endmodule : spi_serial_eeprom_core

// ---- dv/spi_host_model.sv ----
// Host side SPI master model for the EEPROM command core
`timescale 1ns/1ps
module spi_host_model #(
   parameter int HALF = 4
) (
   // Clock
   input  wire logic sys_clk_i,
   // Device pins
   input  wire logic so_i,
   output logic      sck_o,
   output logic      csn_o,
   output logic      si_o,
   output logic      holdn_o
);
   // ----------
   // Pin driving
   // ----------
   // Link clock stands low between frames; idle SI shows the inverse
   initial begin
      sck_o   = 1'b0;
      csn_o   = 1'b1;
      si_o    = 1'b0;
      holdn_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : tick
   task automatic sel();
      tick(1);
      csn_o <= 1'b0;
      tick(HALF);
   endtask : sel
   // Deselect only after the last falling clock edge of the frame
   task automatic desel();
      tick(HALF);
      csn_o <= 1'b1;
      si_o  <= ~si_o;
      tick(3 * HALF);
   endtask : desel
   // SI changes at the falling edge, SO is taken at the rising edge
   task automatic shift(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         si_o <= tx[i];
         tick(HALF);
         sck_o <= 1'b1;
         rx = {rx[6:0], so_i};
         tick(HALF);
         sck_o <= 1'b0;
      end
   endtask : shift
   // Only called while the link clock is low
   task automatic pause(input int n);
      holdn_o <= 1'b0;
      tick(n);
      holdn_o <= 1'b1;
      tick(HALF);
   endtask : pause
endmodule : spi_host_model

// ---- dv/spi_serial_eeprom_core_tb_top.sv ----
// Self-checking bench for the serial EEPROM command core
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
   err_total++; $display("CHECK FAILED t=%0t got %h exp %h", \
   $time, a, e); end end
module spi_serial_eeprom_core_tb_top;
   // ----------
   // Bench state
   // ----------
   // Short write cycle keeps the run brief
   localparam int WC = 800;
   typedef struct {
      logic [7:0]  sr;
      logic [15:0] a;
      logic [7:0]  d;
      logic [7:0]  e;
   } row_t;
   logic       sys_clk_i;
   logic       rstn_i;
   logic       wpn_i;
   logic       sck;
   logic       csn;
   logic       si;
   logic       holdn;
   logic       so;
   logic       so_oen;
   logic       busy;
   logic [7:0] rx;
   logic [7:0] b0;
   logic [7:0] b1;
   int         err_total;
   int         n_compared;
   int         cyc;
   int         drv;
   int         cnt;
   int         snap;
   // Status value, address, data, value read back after protection
   row_t rows [8] = '{
      '{8'h00, 16'h3000, 8'h11, 8'h11}, '{8'h04, 16'h3000, 8'h22, 8'h11},
      '{8'h04, 16'h2fff, 8'h33, 8'h33}, '{8'h00, 16'h2000, 8'h44, 8'h44},
      '{8'h08, 16'h2000, 8'h55, 8'h44}, '{8'h08, 16'h1fff, 8'h66, 8'h66},
      '{8'h00, 16'h0000, 8'h70, 8'h70}, '{8'h0c, 16'h0000, 8'h77, 8'h70}};

   spi_serial_eeprom_core #(.WRITE_CYCLES(WC)) i_spi_serial_eeprom_core (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .sck_i(sck),
      .csn_i(csn), .si_i(si), .holdn_i(holdn), .wpn_i(wpn_i), .so_o(so),
      .so_oen_o(so_oen), .busy_o(busy));
   // A released output reads back inverted, so an undriven read fails
   spi_host_model i_spi_host_model (.sys_clk_i(sys_clk_i),
      .so_i(so_oen ? ~so : so), .sck_o(sck), .csn_o(csn), .si_o(si),
      .holdn_o(holdn));

   // ----------
   // Tasks
   // ----------
   task automatic sh(input logic [7:0] v);
      i_spi_host_model.shift(v, 8, rx);
   endtask : sh
   task automatic op(input logic [7:0] c);
      i_spi_host_model.sel();
      sh(c);
      i_spi_host_model.desel();
   endtask : op
   task automatic rd_sr();
      i_spi_host_model.sel();
      sh(8'h05);
      sh(8'h00);
      i_spi_host_model.desel();
   endtask : rd_sr
   task automatic idle();
      cnt = 0;
      while (busy !== 1'b0 && cnt < WC + 50) begin
         @(posedge sys_clk_i);
         cnt++;
      end
      `CHK(busy, 1'b0)
   endtask : idle
   task automatic wr(input logic [7:0] c, input logic [15:0] a,
                     input logic [7:0] d, input int n, input logic w);
      op(8'h06);
      i_spi_host_model.sel();
      sh(c);
      if (c == 8'h02) begin
         sh(a[15:8]);
         sh(a[7:0]);
      end
      for (int i = 0; i < n; i++) sh(d + 8'(i));
      i_spi_host_model.desel();
      if (w) idle();
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic hold);
      i_spi_host_model.sel();
      sh(8'h03);
      sh(a[15:8]);
      sh(a[7:0]);
      if (hold) fork
         i_spi_host_model.pause(24);
         begin
            repeat (12) @(posedge sys_clk_i);
            `CHK(so_oen, 1'b1)
         end
      join
      sh(8'h00);
      b0 = rx;
      sh(8'h00);
      b1 = rx;
      i_spi_host_model.desel();
   endtask : rd
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   // ----------
   // Clock, timeout, output watch
   // ----------
   always #10 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (so_oen === 1'b0) drv <= drv + 1;
      if (cyc == 60000) begin
         err_total++;
         print_verdict();
      end
   end

   // ----------
   // Sequence
   // ----------
   initial begin
      sys_clk_i = 1'b0;
      rstn_i = 1'b0;
      wpn_i = 1'b1;
      err_total = 0;
      n_compared = 0;
      cyc = 0;
      drv = 0;
      repeat (20) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      `CHK(so_oen, 1'b1)
      `CHK(busy, 1'b0)
      rd_sr();
      `CHK(rx, 8'h00)
      op(8'h06);
      rd_sr();
      `CHK(rx, 8'h02)
      op(8'h04);
      rd_sr();
      `CHK(rx, 8'h00)
      foreach (rows[i]) begin
         wr(8'h01, 16'h0000, rows[i].sr, 1, 1'b1);
         rd_sr();
         `CHK(rx, rows[i].sr)
         wr(8'h02, rows[i].a, rows[i].d, 1, 1'b1);
         wr(8'h01, 16'h0000, 8'h00, 1, 1'b1);
         rd(rows[i].a, 1'b0);
         `CHK(b0, rows[i].e)
      end
      // Three bytes from page offset 62 with the top address bits set
      wr(8'h02, 16'hc0be, 8'ha0, 3, 1'b1);
      rd(16'h00be, 1'b1);
      `CHK(b0, 8'ha0)
      `CHK(b1, 8'ha1)
      rd(16'h0080, 1'b0);
      `CHK(b0, 8'ha2)
      wr(8'h02, 16'h3fff, 8'h5a, 1, 1'b1);
      wr(8'h02, 16'h0000, 8'ha5, 1, 1'b1);
      rd(16'h3fff, 1'b0);
      `CHK({b0, b1}, 16'h5aa5)
      // Accesses while the write cycle runs
      wr(8'h02, 16'h0080, 8'hb7, 1, 1'b0);
      `CHK(busy, 1'b1)
      snap = drv;
      rd(16'h0080, 1'b0);
      `CHK(drv, snap)
      rd_sr();
      `CHK(rx, 8'h03)
      idle();
      `CHK(cnt < WC, 1'b1)
      rd_sr();
      `CHK(rx, 8'h00)
      // Write without a deselect after the latch opcode
      i_spi_host_model.sel();
      sh(8'h06);
      sh(8'h02);
      sh(8'h00);
      sh(8'h80);
      sh(8'h99);
      i_spi_host_model.desel();
      `CHK(busy, 1'b0)
      // Deselect in the middle of a data byte
      op(8'h06);
      i_spi_host_model.sel();
      sh(8'h02);
      sh(8'h00);
      sh(8'h80);
      i_spi_host_model.shift(8'h99, 4, rx);
      i_spi_host_model.desel();
      `CHK(busy, 1'b0)
      op(8'h04);
      rd(16'h0080, 1'b0);
      `CHK(b0, 8'hb7)
      snap = drv;
      op(8'hff);
      `CHK(drv, snap)
      `CHK(so_oen, 1'b1)
      // Pin protection of the status bits
      wr(8'h01, 16'h0000, 8'h80, 1, 1'b1);
      wpn_i <= 1'b0;
      wr(8'h01, 16'h0000, 8'h8c, 1, 1'b0);
      `CHK(busy, 1'b0)
      rd_sr();
      `CHK(rx, 8'h82)
      wpn_i <= 1'b1;
      wr(8'h01, 16'h0000, 8'h00, 1, 1'b1);
      rd_sr();
      `CHK(rx, 8'h00)
      // Reset in mid-run must drop an open latch
      op(8'h06);
      rstn_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      `CHK(so_oen, 1'b1)
      rd_sr();
      `CHK(rx, 8'h00)
      print_verdict();
   end
endmodule : spi_serial_eeprom_core_tb_top
